/* File: adcrb_regs.svh */
// Register offsets, field positions, reset values and codes of the converter register bank
`ifndef ADCRB_REGS_SVH
`define ADCRB_REGS_SVH
`define A_SEL 8'h10
`define A_OFS_BIG 8'h20
`define A_OFS_SML 8'h21
`define A_GN_BIG 8'h22
`define A_GN_MID 8'h23
`define A_GN_SML 8'h24
`define A_PWR 8'h25
`define A_SLIP 8'h71
`define A_DIV 8'h72
`define A_OUT 8'h73
`define A_TIM 8'h74
`define A_STAT 8'h75
`define A_TP 8'hC0
`define A_W1L 8'hC2
`define A_W1H 8'hC3
`define A_W2L 8'hC4
`define A_W2H 8'hC5
`define SEL_RST 8'h00
`define SEL_ONE 8'h01
`define ERR_CODE 8'hAD
`define TRIM_MID 8'h80
`define GAIN_MASK 8'h0F
`define OUT_MASK 8'hE7
`define TIM_MASK 8'h50
`define TIM_RST 8'h10
`define TP_MASK 8'hCF
`define DLL_BIT 6
`define DDR_BIT 4
`define DRV_HI 7
`define DRV_LO 5
`define FMT_HI 2
`define FMT_LO 0
`define TPM_HI 7
`define TPM_LO 6
`define TPS_HI 3
`define TPS_LO 0
`define CODE_PIN 3'h0
`define CODE_1 3'h1
`define CODE_2 3'h2
`define CODE_4 3'h4
`define STRAP_NORM 2'h0
`define STRAP_SLEEP 2'h1
`define STRAP_NAP 2'h2
`define TM_STAT 2'h0
`define TM_ALT 2'h1
`define TP_RST 8'h00
`define TP_OFF 4'h0
`define TP_MID 4'h1
`define TP_PFS 4'h2
`define TP_NFS 4'h3
`define TP_CHK 4'h4
`define TP_ONE 4'h7
`define TP_USR 4'h8
`define W_MID 16'h8000
`define W_ONES 16'hFFFF
`define W_ZERO 16'h0000
`define W_CHK1 16'hAAAA
`define W_CHK2 16'h5555
`define TP_LAT 3'h4
`define WORD_RST 16'h0000
`endif

/* File: adcrb_pkg.sv */
// Types shared by the converter register bank
package adcrb_pkg;
   typedef enum logic [1:0] {
      TP_IDLE = 2'b00,
      TP_WAIT = 2'b01,
      TP_RUN = 2'b10
   } adcrb_tp_e;

   typedef struct packed {
      logic [7:0] ofs_big;
      logic [7:0] ofs_sml;
      logic [7:0] gn_big;
      logic [7:0] gn_mid;
      logic [7:0] gn_sml;
   } adcrb_trim_s;

   typedef struct packed {
      logic [2:0] pd_mode;
      logic [2:0] div;
      logic [2:0] drv;
      logic [2:0] fmt;
      logic dll_slow;
      logic ddr;
   } adcrb_cfg_s;

   typedef struct packed {
      logic [7:0] sel;
      adcrb_trim_s trim;
      adcrb_trim_s cal;
      logic [2:0] pwr;
      logic slip;
      logic slip_p;
      logic [2:0] div;
      logic [7:0] outm;
      logic [7:0] tim;
      logic [7:0] tp;
      logic [15:0] w1;
      logic [15:0] w2;
      adcrb_tp_e tp_st;
      logic [2:0] tp_cnt;
      logic phase;
      logic [15:0] word;
      logic [7:0] rdata;
      logic rvalid;
      adcrb_cfg_s cfg;
   } adcrb_state_s;
endpackage

/* File: adcrb_top.sv */
// Converter configuration register bank: trims, power-down, clocking, output and test words
`timescale 1ns/100ps
`include "adcrb_regs.svh"

module adcrb_top (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic soft_reset_i,
   input wire logic cal_load_i,
   input wire adcrb_pkg::adcrb_trim_s cal_i,
   input wire logic [7:0] setup_state_i,
   input wire logic [1:0] low_power_strap_pin_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output adcrb_pkg::adcrb_trim_s trim_o,
   output adcrb_pkg::adcrb_cfg_s cfg_o,
   output logic slip_pulse_o,
   output logic test_en_o,
   output logic [15:0] test_word_o
);
   import adcrb_pkg::*;

   adcrb_state_s s_r;
   adcrb_state_s s_nxt;
   logic sel_ok;
   logic idx_acc;
   logic [15:0] wa;
   logic [15:0] wb;

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   function automatic logic [7:0] rd_mux(input adcrb_state_s s, input logic [7:0] a,
                                         input logic [7:0] st);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         `A_SEL: v = s.sel;
         `A_OFS_BIG: v = s.trim.ofs_big;
         `A_OFS_SML: v = s.trim.ofs_sml;
         `A_GN_BIG: v = s.trim.gn_big;
         `A_GN_MID: v = s.trim.gn_mid;
         `A_GN_SML: v = s.trim.gn_sml;
         `A_PWR: v = {5'h00, s.pwr};
         `A_SLIP: v = {7'h00, s.slip};
         `A_DIV: v = {5'h00, s.div};
         `A_OUT: v = s.outm;
         `A_TIM: v = s.tim;
         `A_STAT: v = st;
         `A_TP: v = s.tp;
         `A_W1L: v = s.w1[7:0];
         `A_W1H: v = s.w1[15:8];
         `A_W2L: v = s.w2[7:0];
         `A_W2H: v = s.w2[15:8];
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   assign sel_ok = (s_r.sel == `SEL_ONE);
   assign idx_acc = (addr_i >= `A_OFS_BIG) && (addr_i <= `A_PWR);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.rvalid = 1'b0;
      s_nxt.slip_p = 1'b0;
      wa = `W_ZERO;
      wb = `W_ZERO;
      if (soft_reset_i) begin
         // Power, divider and output registers deliberately kept
         s_nxt.sel = `SEL_RST;
         s_nxt.trim = s_r.cal;
         s_nxt.slip = 1'b0;
         s_nxt.tim = `TIM_RST;
         s_nxt.tp = `TP_RST;
         s_nxt.w1 = `WORD_RST;
         s_nxt.w2 = `WORD_RST;
      end else if (wr_en_i) begin
         unique case (addr_i)
            `A_SEL: s_nxt.sel = wdata_i;
            `A_OFS_BIG: if (sel_ok) s_nxt.trim.ofs_big = wdata_i;
            `A_OFS_SML: if (sel_ok) s_nxt.trim.ofs_sml = wdata_i;
            `A_GN_BIG: if (sel_ok) s_nxt.trim.gn_big = wdata_i & `GAIN_MASK;
            `A_GN_MID: if (sel_ok) s_nxt.trim.gn_mid = wdata_i;
            `A_GN_SML: if (sel_ok) s_nxt.trim.gn_sml = wdata_i;
            `A_PWR: if (sel_ok) s_nxt.pwr = wdata_i[2:0];
            `A_SLIP: begin
               s_nxt.slip = wdata_i[0];
               s_nxt.slip_p = wdata_i[0] & ~s_r.slip;
            end
            `A_DIV: s_nxt.div = wdata_i[2:0];
            `A_OUT: s_nxt.outm = wdata_i & `OUT_MASK;
            // Undo the host's xor masking so the desired value lands
            `A_TIM: s_nxt.tim = (wdata_i ^ s_r.tim ^ setup_state_i) & `TIM_MASK;
            `A_TP: s_nxt.tp = wdata_i & `TP_MASK;
            `A_W1L: s_nxt.w1[7:0] = wdata_i;
            `A_W1H: s_nxt.w1[15:8] = wdata_i;
            `A_W2L: s_nxt.w2[7:0] = wdata_i;
            `A_W2H: s_nxt.w2[15:8] = wdata_i;
            default: ;
         endcase
      end
      // Calibration result becomes the current trim and the soft-reset value
      if (cal_load_i) begin
         s_nxt.cal = cal_i;
         s_nxt.trim = cal_i;
         s_nxt.trim.gn_big = cal_i.gn_big & `GAIN_MASK;
         s_nxt.cal.gn_big = cal_i.gn_big & `GAIN_MASK;
      end
      if (rd_en_i) begin
         s_nxt.rvalid = 1'b1;
         if (idx_acc && !sel_ok) begin
            s_nxt.rdata = `ERR_CODE;
         end else begin
            s_nxt.rdata = rd_mux(s_r, addr_i, setup_state_i);
         end
      end

      // Test pattern engine: enable lags the setting by a fixed wait
      s_nxt.phase = ~s_r.phase;
      if (s_nxt.tp != s_r.tp) begin
         s_nxt.tp_st = TP_WAIT;
         s_nxt.tp_cnt = `TP_LAT;
      end else begin
         unique case (s_r.tp_st)
            TP_IDLE: ;
            TP_WAIT: begin
               s_nxt.tp_cnt = s_r.tp_cnt - 3'h1;
               if (s_r.tp_cnt == 3'h1) begin
                  s_nxt.tp_st = (s_r.tp[`TPS_HI:`TPS_LO] == `TP_OFF) ? TP_IDLE : TP_RUN;
               end
            end
            TP_RUN: ;
            default: s_nxt.tp_st = TP_IDLE;
         endcase
      end
      unique case (s_r.tp[`TPS_HI:`TPS_LO])
         `TP_MID: begin
            wa = `W_MID;
            wb = `W_MID;
         end
         `TP_PFS: begin
            wa = `W_ONES;
            wb = `W_ONES;
         end
         `TP_NFS: begin
            wa = `W_ZERO;
            wb = `W_ZERO;
         end
         `TP_CHK: begin
            wa = `W_CHK1;
            wb = `W_CHK2;
         end
         `TP_ONE: begin
            wa = `W_ONES;
            wb = `W_ZERO;
         end
         `TP_USR: begin
            wa = s_r.w1;
            wb = s_r.w2;
         end
         default: begin
            wa = `W_ZERO;
            wb = `W_ZERO;
         end
      endcase
      // Static mode repeats word 1; alternate mode swaps each phase
      if ((s_r.tp[`TPM_HI:`TPM_LO] == `TM_ALT) && s_r.phase) begin
         s_nxt.word = wb;
      end else begin
         s_nxt.word = wa;
      end

      // Resolve pin-controlled fields; this package has no divider or output straps
      unique case (s_nxt.pwr)
         `CODE_PIN: begin
            unique case (low_power_strap_pin_i)
               `STRAP_SLEEP: s_nxt.cfg.pd_mode = `CODE_4;
               `STRAP_NAP: s_nxt.cfg.pd_mode = `CODE_2;
               default: s_nxt.cfg.pd_mode = `CODE_1;
            endcase
         end
         default: s_nxt.cfg.pd_mode = s_nxt.pwr;
      endcase
      s_nxt.cfg.div = (s_nxt.div == `CODE_PIN) ? `CODE_1 : s_nxt.div;
      s_nxt.cfg.drv = (s_nxt.outm[`DRV_HI:`DRV_LO] == `CODE_PIN) ? `CODE_2 :
                      s_nxt.outm[`DRV_HI:`DRV_LO];
      s_nxt.cfg.fmt = (s_nxt.outm[`FMT_HI:`FMT_LO] == `CODE_PIN) ? `CODE_1 :
                      s_nxt.outm[`FMT_HI:`FMT_LO];
      s_nxt.cfg.dll_slow = s_nxt.tim[`DLL_BIT];
      s_nxt.cfg.ddr = s_nxt.tim[`DDR_BIT];
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_r <= '0;
         s_r.sel <= `SEL_RST;
         s_r.trim <= {5{`TRIM_MID}};
         s_r.trim.gn_big <= 8'h00;
         s_r.cal <= {5{`TRIM_MID}};
         s_r.cal.gn_big <= 8'h00;
         s_r.tim <= `TIM_RST;
         s_r.tp_st <= TP_IDLE;
         s_r.cfg.pd_mode <= `CODE_1;
         s_r.cfg.div <= `CODE_1;
         s_r.cfg.drv <= `CODE_2;
         s_r.cfg.fmt <= `CODE_1;
         s_r.cfg.ddr <= 1'b1;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   assign rdata_o = s_r.rdata;
   assign rvalid_o = s_r.rvalid;
   assign trim_o = s_r.trim;
   assign cfg_o = s_r.cfg;
   assign slip_pulse_o = s_r.slip_p;
   assign test_en_o = (s_r.tp_st == TP_RUN);
   assign test_word_o = s_r.word;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);

   a_idx_write_gate: assert property (
      ce_i && wr_en_i && !soft_reset_i && addr_i == `A_PWR && !sel_ok
      |=> s_r.pwr == $past(s_r.pwr))
      else $error("power-down changed without valid select");

   a_idx_read_err: assert property (
      ce_i && rd_en_i && idx_acc && !sel_ok |=> rvalid_o && rdata_o == `ERR_CODE)
      else $error("indexed read without select did not give error code");

   a_cal_load: assert property (
      ce_i && cal_load_i |=> trim_o.ofs_big == $past(cal_i.ofs_big)
                             && trim_o.gn_mid == $past(cal_i.gn_mid))
      else $error("calibration value not loaded");

   a_gain_width: assert property (
      trim_o.gn_big[7:4] == 4'h0)
      else $error("coarse gain upper bits set");

   a_soft_keep: assert property (
      ce_i && soft_reset_i |=> s_r.pwr == $past(s_r.pwr) && s_r.div == $past(s_r.div)
                               && s_r.outm == $past(s_r.outm) && s_r.sel == `SEL_RST)
      else $error("soft reset disturbed kept registers");

   a_slip_edge: assert property (
      ce_i && wr_en_i && !soft_reset_i && addr_i == `A_SLIP && wdata_i[0] && !s_r.slip
      |=> slip_pulse_o)
      else $error("phase slip pulse missing");

   a_slip_cause: assert property (
      $rose(slip_pulse_o) |-> $past(wr_en_i) && $past(addr_i) == `A_SLIP && !$past(s_r.slip))
      else $error("phase slip pulse without 0 to 1 write");

   a_tim_xor: assert property (
      ce_i && wr_en_i && !soft_reset_i && addr_i == `A_TIM
      |=> s_r.tim == (($past(wdata_i) ^ $past(s_r.tim) ^ $past(setup_state_i)) & `TIM_MASK))
      else $error("output timing xor write wrong");

   a_ddr_default: assert property (
      ce_i && soft_reset_i |=> s_r.tim[`DDR_BIT] && !s_r.tim[`DLL_BIT])
      else $error("timing defaults not restored");

   a_div_default: assert property (
      s_r.div == `CODE_PIN |-> cfg_o.div == `CODE_1)
      else $error("divider default not divide by one");

   a_tp_latency: assert property (
      $rose(test_en_o) |-> $past(s_r.tp_st) == TP_WAIT && $past(s_r.tp_cnt) == 3'h1)
      else $error("test pattern enabled without wait");

   a_slip_single: assert property (
      ce_i && slip_pulse_o |=> !slip_pulse_o)
      else $error("phase slip pulse longer than one cycle");

   a_sel_read: assert property (
      ce_i && rd_en_i && addr_i == `A_SEL |=> rvalid_o && rdata_o == $past(s_r.sel))
      else $error("converter select read back wrong");

   a_soft_trim: assert property (
      ce_i && soft_reset_i && !cal_load_i |=> trim_o == $past(s_r.cal) && s_r.w1 == `WORD_RST)
      else $error("soft reset did not restore defaults");

   // ------------------------------------------------------------
   // Assertions: output resolution and test words
   // ------------------------------------------------------------
   a_pd_override: assert property (
      s_r.pwr != `CODE_PIN |-> cfg_o.pd_mode == s_r.pwr)
      else $error("power-down register did not override strap");

   a_pd_strap: assert property (
      ce_i && s_nxt.pwr == `CODE_PIN && low_power_strap_pin_i == `STRAP_SLEEP
      |=> cfg_o.pd_mode == `CODE_4)
      else $error("sleep strap not followed under pin control");

   a_div_pass: assert property (
      s_r.div != `CODE_PIN |-> cfg_o.div == s_r.div)
      else $error("divider code not passed through");

   a_drv_pass: assert property (
      s_r.outm[`DRV_HI:`DRV_LO] != `CODE_PIN |-> cfg_o.drv == s_r.outm[`DRV_HI:`DRV_LO])
      else $error("driver code not passed through");

   a_fmt_pass: assert property (
      s_r.outm[`FMT_HI:`FMT_LO] != `CODE_PIN |-> cfg_o.fmt == s_r.outm[`FMT_HI:`FMT_LO])
      else $error("coding code not passed through");

   a_out_default: assert property (
      s_r.outm[`DRV_HI:`DRV_LO] == `CODE_PIN && s_r.outm[`FMT_HI:`FMT_LO] == `CODE_PIN
      |-> cfg_o.drv == `CODE_2 && cfg_o.fmt == `CODE_1)
      else $error("output defaults wrong without straps");

   a_tim_bits: assert property (
      (s_r.tim & ~`TIM_MASK) == 8'h00)
      else $error("output timing holds undefined bits");

   a_chk_words: assert property (
      ce_i && s_r.tp[`TPS_HI:`TPS_LO] == `TP_CHK
      |=> test_word_o == `W_CHK1 || test_word_o == `W_CHK2)
      else $error("checkerboard word wrong");

   a_alt_toggle: assert property (
      ce_i && $past(ce_i) && $stable(s_r.tp) && s_r.tp[`TPM_HI:`TPM_LO] == `TM_ALT
      && s_r.tp[`TPS_HI:`TPS_LO] == `TP_ONE |=> test_word_o != $past(test_word_o))
      else $error("alternate words did not swap");

   a_user_static: assert property (
      ce_i && s_r.tp[`TPS_HI:`TPS_LO] == `TP_USR && s_r.tp[`TPM_HI:`TPM_LO] == `TM_STAT
      |=> test_word_o == $past(s_r.w1))
      else $error("static user word wrong");

   c_nap_entry: cover property (ce_i && wr_en_i && addr_i == `A_PWR && sel_ok
                                && wdata_i[2:0] == `CODE_2);
   c_slip: cover property (slip_pulse_o);
   c_err_read: cover property (rvalid_o && rdata_o == `ERR_CODE);
   c_test_run: cover property (test_en_o && s_r.tp[`TPS_HI:`TPS_LO] == `TP_USR);
endmodule

/* File: adcrb_host.sv */
// Host controller model that drives the register port of the converter bank
`timescale 1ns/100ps
`include "adcrb_regs.svh"

module adcrb_host (
   input wire logic clk_sys_i,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i,
   output logic ce_o,
   output logic wr_en_o,
   output logic rd_en_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   initial begin
      ce_o = 1'b1;
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o = 8'hFF;
      wdata_o = 8'hFF;
   end

   task automatic set_ce(input logic v);
      ce_o = v;
   endtask

   // Released bus shows the inverse so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      addr_o = a;
      wdata_o = d;
      wr_en_o = 1'b1;
      @(negedge clk_sys_i);
      wr_en_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
      int n;
      @(negedge clk_sys_i);
      addr_o = a;
      rd_en_o = 1'b1;
      @(negedge clk_sys_i);
      rd_en_o = 1'b0;
      addr_o = ~a;
      ok = 1'b0;
      d = 8'h00;
      for (n = 0; n < 4 && !ok; n++) begin
         if (rvalid_i === 1'b1) begin
            d = rdata_i;
            ok = 1'b1;
         end else begin
            @(negedge clk_sys_i);
         end
      end
   endtask

   // Second select write aims at no converter, so the repeat is harmless
   task automatic pd_seq(input logic [7:0] m);
      wr(`A_SEL, `SEL_ONE);
      wr(`A_PWR, m);
      wr(`A_SEL, 8'h02);
      wr(`A_PWR, m);
   endtask

   task automatic set_timing(input logic [7:0] want, output bit ok);
      logic [7:0] old;
      logic [7:0] st;
      bit ok2;
      rd(`A_TIM, old, ok);
      rd(`A_STAT, st, ok2);
      ok = ok & ok2;
      wr(`A_TIM, old ^ st ^ (want | 8'h10));
   endtask
endmodule

/* File: adcrb_top_test.sv */
// Self-checking testbench of the converter register bank
`timescale 1ns/100ps
`include "adcrb_regs.svh"

module adcrb_top_test;
   import adcrb_pkg::*;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic ce, wr_en, rd_en, rvalid, slip, test_en;
   logic [7:0] addr, wdata, rdata;
   logic soft_reset = 1'b0;
   logic cal_load = 1'b0;
   adcrb_trim_s cal = '0;
   adcrb_trim_s trim;
   adcrb_cfg_s cfg;
   logic [7:0] setup_state = 8'h00;
   logic [1:0] strap = `STRAP_NORM;
   logic [15:0] word;
   int mismatches = 0;
   int checks_done = 0;

   always #2.5 clk_sys_i = ~clk_sys_i;

   adcrb_host adcrb_host_i (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .rvalid_i(rvalid),
      .ce_o(ce), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));

   adcrb_top adcrb_top_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce),
      .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata),
      .soft_reset_i(soft_reset), .cal_load_i(cal_load), .cal_i(cal),
      .setup_state_i(setup_state), .low_power_strap_pin_i(strap), .rdata_o(rdata),
      .rvalid_o(rvalid), .trim_o(trim), .cfg_o(cfg), .slip_pulse_o(slip),
      .test_en_o(test_en), .test_word_o(word));

   // ------------------------------
   // Shared helpers
   // ------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      adcrb_host_i.wr(a, d);
   endtask

   task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      bit ok;
      adcrb_host_i.rd(a, d, ok);
      if (!ok) begin
         mismatches++;
         give_verdict();
      end else
         check(what, d, exp);
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_reset();
      check("pd", cfg.pd_mode, `CODE_1);
      check("div", cfg.div, `CODE_1);
      check("drv", cfg.drv, `CODE_2);
      check("fmt", cfg.fmt, `CODE_1);
      check("dll", cfg.dll_slow, 1'b0);
      check("ddr", cfg.ddr, 1'b1);
      rchk("sel", `A_SEL, `SEL_RST);
      rchk("err", `A_OFS_BIG, `ERR_CODE);
      rchk("unmapped", 8'h30, 8'h00);
   endtask

   task automatic t_trim();
      cal = 40'h11_22_F3_44_55;
      cal_load = 1'b1;
      cyc(1);
      cal_load = 1'b0;
      cyc(2);
      check("cal", trim, 40'h11_22_03_44_55);
      wr(`A_OFS_BIG, 8'h90);
      cyc(2);
      check("unsel", trim.ofs_big, 8'h11);
      wr(`A_SEL, `SEL_ONE);
      rchk("ofs rd", `A_OFS_BIG, 8'h11);
      wr(`A_OFS_BIG, 8'h12);
      rchk("ofs wr", `A_OFS_BIG, 8'h12);
      wr(`A_GN_BIG, 8'hFF);
      rchk("gain4", `A_GN_BIG, 8'h0F);
      wr(`A_GN_SML, 8'hFF);
      wr(`A_GN_MID, 8'h80);
      cyc(2);
      check("gain8", {trim.gn_mid, trim.gn_sml}, 16'h80FF);
   endtask

   task automatic t_power();
      adcrb_host_i.pd_seq(8'h02);
      cyc(2);
      check("nap", cfg.pd_mode, `CODE_2);
      adcrb_host_i.pd_seq(8'h01);
      cyc(2);
      check("wake", cfg.pd_mode, `CODE_1);
      wr(`A_SEL, `SEL_ONE);
      wr(`A_PWR, 8'h00);
      strap = `STRAP_NAP;
      cyc(2);
      check("pin nap", cfg.pd_mode, `CODE_2);
      strap = `STRAP_SLEEP;
      cyc(2);
      check("pin sleep", cfg.pd_mode, `CODE_4);
      strap = `STRAP_NORM;
      wr(`A_PWR, 8'h04);
      cyc(2);
      check("sleep", cfg.pd_mode, `CODE_4);
   endtask

   task automatic t_clk_out();
      logic [2:0] c [3] = '{`CODE_1, `CODE_2, `CODE_4};
      for (int i = 0; i < 3; i++) begin
         wr(`A_DIV, {5'h00, c[i]});
         wr(`A_OUT, {c[i], 2'b00, c[i]});
         cyc(2);
         check("div set", cfg.div, c[i]);
         check("drv set", cfg.drv, c[i]);
         check("fmt set", cfg.fmt, c[i]);
      end
      wr(`A_OUT, 8'h82);
      wr(`A_OFS_BIG, 8'h77);
      soft_reset = 1'b1;
      cyc(1);
      soft_reset = 1'b0;
      cyc(2);
      check("keep", {cfg.pd_mode, cfg.div, cfg.drv, cfg.fmt}, 12'h922);
      check("trim back", trim.ofs_big, 8'h11);
      rchk("sel back", `A_SEL, `SEL_RST);
      rchk("tim back", `A_TIM, `TIM_RST);
   endtask

   task automatic t_slip(input logic [7:0] d, input int exp);
      int n = 0;
      wr(`A_SLIP, d);
      for (int i = 0; i < 4; i++) begin
         n += (slip === 1'b1);
         cyc(1);
      end
      check("slip", n, exp);
   endtask

   task automatic t_timing(input logic [7:0] want);
      bit ok;
      setup_state = 8'h44;
      adcrb_host_i.set_timing(want, ok);
      cyc(2);
      check("rd ok", ok, 1'b1);
      check("dll", cfg.dll_slow, want[`DLL_BIT]);
      check("ddr", cfg.ddr, 1'b1);
      rchk("tim", `A_TIM, want | 8'h10);
   endtask

   task automatic t_pattern(input logic [7:0] tp, input logic [15:0] w1, input logic [15:0] w2);
      logic [15:0] a;
      logic [15:0] b;
      wr(`A_TP, tp);
      cyc(7);
      a = word;
      cyc(1);
      b = word;
      check("tp en", test_en, tp[3:0] != 4'h0);
      check("word pair", ({a, b} === {w1, w2}) || ({a, b} === {w2, w1}), 1'b1);
      cyc(1);
      check("word again", word, a);
   endtask

   task automatic t_freeze();
      wr(`A_SEL, `SEL_ONE);
      adcrb_host_i.set_ce(1'b0);
      soft_reset = 1'b1;
      cyc(2);
      soft_reset = 1'b0;
      adcrb_host_i.set_ce(1'b1);
      rchk("frozen", `A_SEL, `SEL_ONE);
   endtask

   task automatic t_words();
      wr(`A_W1L, 8'h34);
      wr(`A_W1H, 8'h12);
      wr(`A_W2L, 8'h78);
      wr(`A_W2H, 8'h56);
      rchk("w1 high", `A_W1H, 8'h12);
   endtask

   task automatic t_latency();
      wr(`A_TP, 8'h01);
      cyc(3);
      check("tp early", test_en, 1'b0);
      cyc(1);
      check("tp late", test_en, 1'b1);
   endtask

   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      cyc(10);
      resetn_i = 1'b1;
      cyc(1);
      t_reset();
      t_trim();
      t_power();
      t_clk_out();
      t_freeze();
      t_slip(8'h00, 0);
      t_slip(8'h01, 1);
      t_slip(8'h01, 0);
      t_timing(8'h50);
      t_timing(8'h10);
      t_words();
      t_latency();
      t_pattern(8'h01, `W_MID, `W_MID);
      t_pattern(8'h02, `W_ONES, `W_ONES);
      t_pattern(8'h03, `W_ZERO, `W_ZERO);
      t_pattern(8'h44, `W_CHK1, `W_CHK2);
      t_pattern(8'h47, `W_ONES, `W_ZERO);
      t_pattern(8'h05, `W_ZERO, `W_ZERO);
      t_pattern(8'h08, 16'h1234, 16'h1234);
      t_pattern(8'h48, 16'h1234, 16'h5678);
      t_pattern(8'h00, `W_ZERO, `W_ZERO);
      give_verdict();
   end

   // Hang guard
   initial begin
      #400000;
      mismatches++;
      give_verdict();
   end
endmodule
